//--- accdet_pkg.sv
// Shared constants and types for the accessory detection register bank.
package accdet_pkg;

  // Clock and time units.
  localparam int CLK_MHZ = 125;
  localparam int US_CYCLES = CLK_MHZ;
  localparam int US_PER_MS = 1000;
  localparam logic [6:0] US_DIV_LAST = 7'(US_CYCLES - 1);

  // Filter times for jack insertion and removal.
  localparam int DEB_INS_FAST_MS = 3;
  localparam int DEB_REM_FAST_MS = 12;
  localparam int DEB_INS_SLOW_MS = 20;
  localparam int DEB_REM_SLOW_MS = 80;

  // Test pulse widths in microseconds, by select code.
  localparam logic [7:0] PW_SEL0_US = 8'h32;
  localparam logic [7:0] PW_SEL1_US = 8'h19;
  localparam logic [7:0] PW_SEL2_US = 8'h64;
  localparam logic [7:0] PW_SEL3_US = 8'hC8;

  // Register offsets.
  localparam logic [7:0] ADDR_STATE = 8'h19;
  localparam logic [7:0] ADDR_PULSE = 8'h1A;
  localparam logic [7:0] ADDR_SPARE = 8'h1B;
  localparam logic [7:0] ADDR_CLKCTL = 8'h1C;
  localparam logic [7:0] ADDR_POWER = 8'h1D;
  localparam logic [7:0] ADDR_TEST_SEL = 8'h66;
  localparam logic [7:0] ADDR_TEST_VAL = 8'h6F;

  // Field positions.
  localparam int REPORT_BIT = 7;
  localparam int FILTER_BIT = 7;
  localparam int COUNT_LSB = 4;
  localparam int WIDTH_LSB = 2;
  localparam int LEVEL_LSB = 0;
  localparam int SCAN_BIT = 7;
  localparam int PWR_BIT = 7;
  localparam int SLEEP_BIT = 6;

  // Reset values.
  localparam logic [7:0] STATE_RST = 8'h80;
  localparam logic [7:0] PULSE_RST = 8'h15;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST = 8'h01;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;

  // Accessory codes.
  localparam logic [6:0] CODE_NONE = 7'h00;
  localparam logic [6:0] CODE_HS_STD = 7'h01;
  localparam logic [6:0] CODE_HS_SWAP = 7'h02;
  localparam logic [6:0] CODE_MONO_LO = 7'h0A;
  localparam logic [6:0] CODE_MONO_HI = 7'h0F;
  localparam logic [6:0] CODE_HP_LO = 7'h10;
  localparam logic [6:0] CODE_HP_HI = 7'h12;
  localparam logic [6:0] CODE_LINE_BOTH = 7'h1A;
  localparam logic [6:0] CODE_LINE_TIP = 7'h1B;
  localparam logic [6:0] CODE_LINE_RING = 7'h1C;
  localparam logic [6:0] CODE_UNSUP = 7'h1F;

  typedef enum logic [1:0] {PH_IDLE, PH_PULSE, PH_GAP, PH_FINISH} phase_t;

  function automatic logic code_known(input logic [6:0] c);
    code_known = (c == CODE_HS_STD) || (c == CODE_HS_SWAP) ||
                 (c >= CODE_MONO_LO && c <= CODE_MONO_HI) ||
                 (c >= CODE_HP_LO && c <= CODE_HP_HI) ||
                 (c >= CODE_LINE_BOTH && c <= CODE_LINE_RING);
  endfunction : code_known

  function automatic logic [7:0] width_us(input logic [1:0] sel);
    case (sel)
      2'h0: width_us = PW_SEL0_US;
      2'h1: width_us = PW_SEL1_US;
      2'h2: width_us = PW_SEL2_US;
      default: width_us = PW_SEL3_US;
    endcase
  endfunction : width_us

endpackage : accdet_pkg

//--- accessory_detect_config.sv
// Accessory detection registers, detection pulse sequencer and scan clock gate.
// Notes on behaviour
// - Code 00 nothing; 0A-0F mono; 10-12 headphone; 1F unsupported.
// - Code 01 standard headset, 02 swapped mic/ground.
// - Line cable codes 1A, 1B tip open, 1C ring open.
// - Filter select picks 3/12 or 20/80 ms.
// - Repeat field gives 1, 2, 4, 8 runs; resets 01.
// - Final result averages all repeated runs.
// - Width field gives 50, 25, 100, 200 us; resets 01.
// - Level field gives supply/36, /72, /18, /9; resets 01.
// - Scan clock bit enables button scan clock when allowed.
// - Report bit low forces code; high reports detection.
// - Only a power-on rise reruns detection.
module accessory_detect_config #(
  parameter int DEB_INS_FAST_US = accdet_pkg::DEB_INS_FAST_MS * accdet_pkg::US_PER_MS,
  parameter int DEB_REM_FAST_US = accdet_pkg::DEB_REM_FAST_MS * accdet_pkg::US_PER_MS,
  parameter int DEB_INS_SLOW_US = accdet_pkg::DEB_INS_SLOW_MS * accdet_pkg::US_PER_MS,
  parameter int DEB_REM_SLOW_US = accdet_pkg::DEB_REM_SLOW_MS * accdet_pkg::US_PER_MS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Jack switch and analog classifier
  input wire logic jack_open_i,
  input wire logic [6:0] probe_code_i,
  // Detection pulse drive
  output logic pulse_o,
  output logic [1:0] pulse_level_o,
  output logic busy_o,
  // Load configuration and status
  output logic [6:0] load_state_o,
  output logic inserted_o,
  output logic power_on_o,
  output logic sleep_mode_o,
  output logic scan_clk_en_o
);

  typedef struct packed {
    logic jack_s1;
    logic jack_s2;
    logic [6:0] probe_s1;
    logic [6:0] probe_s2;
    logic report_mode;
    logic [6:0] state_code;
    logic filter_sel;
    logic [1:0] pulse_count;
    logic [1:0] pulse_width;
    logic [1:0] pulse_level;
    logic [7:0] spare;
    logic scan_clk;
    logic [6:0] clk_rsvd;
    logic [7:0] test_sel;
    logic [7:0] test_val;
    logic power_on;
    logic sleep;
    logic power_prev;
    logic ins_prev;
    accdet_pkg::phase_t phase;
    logic [6:0] us_div;
    logic [7:0] tick_cnt;
    logic [2:0] rep_left;
    logic pulse;
    logic [1:0] run_level;
    logic [1:0] run_count;
    logic [7:0] rdata;
    logic [3:0] samp_cnt;
    logic [14:0] pulse_len;
  } ctl_t;

  ctl_t q;
  ctl_t d;
  logic tick;
  logic inserted;
  logic start;
  logic pulse_end;
  logic [7:0] rd_mux;
  logic [6:0] result;
  logic [7:0] width_last;

  avg_if av ();

  // The jack filter counts microsecond enables, not clock cycles.
  jack_filter #(
    .INS_FAST(DEB_INS_FAST_US),
    .REM_FAST(DEB_REM_FAST_US),
    .INS_SLOW(DEB_INS_SLOW_US),
    .REM_SLOW(DEB_REM_SLOW_US)
  ) u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .raw_i(q.jack_s2),
    .slow_i(q.filter_sel),
    .level_o(inserted)
  );

  pulse_avg u_avg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .av(av.calc)
  );

  assign tick = (q.us_div == accdet_pkg::US_DIV_LAST);
  assign width_last = accdet_pkg::width_us(q.pulse_width) - 8'h01;
  assign pulse_end = tick && (q.tick_cnt == width_last);

  // A fresh run needs the power bit to rise while an accessory is present.
  assign start = q.power_on && !q.power_prev && inserted
                 && (q.phase == accdet_pkg::PH_IDLE);

  // A mean of the classifier reports that falls outside the table reads as unsupported.
  always_comb begin
    if (!inserted) begin
      result = accdet_pkg::CODE_NONE;
    end else if (accdet_pkg::code_known(av.mean)) begin
      result = av.mean;
    end else begin
      result = accdet_pkg::CODE_UNSUP;
    end
  end

  always_comb begin
    case (addr_i)
      accdet_pkg::ADDR_STATE: rd_mux = {q.report_mode, q.state_code};
      accdet_pkg::ADDR_PULSE: rd_mux = {q.filter_sel, 1'b0, q.pulse_count,
                                        q.pulse_width, q.pulse_level};
      accdet_pkg::ADDR_SPARE: rd_mux = q.spare;
      accdet_pkg::ADDR_CLKCTL: rd_mux = {q.scan_clk, q.clk_rsvd};
      accdet_pkg::ADDR_POWER: rd_mux = {q.power_on, q.sleep, 6'h00};
      accdet_pkg::ADDR_TEST_SEL: rd_mux = q.test_sel;
      accdet_pkg::ADDR_TEST_VAL: rd_mux = q.test_val;
      default: rd_mux = 8'h00;
    endcase
  end

  assign av.sample = q.probe_s2;
  // The shift is taken at run start so that a write to the repeat field during a run
  // cannot skew the mean.
  assign av.shift = q.run_count;

  always_comb begin
    d = q;
    av.clear = 1'b0;
    av.valid = 1'b0;
    d.jack_s1 = jack_open_i;
    d.jack_s2 = q.jack_s1;
    d.probe_s1 = probe_code_i;
    d.probe_s2 = q.probe_s1;
    d.us_div = tick ? 7'h00 : q.us_div + 7'h01;
    d.power_prev = q.power_on;
    d.ins_prev = inserted;
    d.rdata = rd_i ? rd_mux : 8'h00;
    d.pulse_len = q.pulse ? q.pulse_len + 15'h0001 : 15'h0000;

    if (wr_i) begin
      case (addr_i)
        accdet_pkg::ADDR_STATE: begin
          d.report_mode = wdata_i[accdet_pkg::REPORT_BIT];
          d.state_code = wdata_i[6:0];
        end
        accdet_pkg::ADDR_PULSE: begin
          d.filter_sel = wdata_i[accdet_pkg::FILTER_BIT];
          d.pulse_count = wdata_i[accdet_pkg::COUNT_LSB +: 2];
          d.pulse_width = wdata_i[accdet_pkg::WIDTH_LSB +: 2];
          d.pulse_level = wdata_i[accdet_pkg::LEVEL_LSB +: 2];
        end
        accdet_pkg::ADDR_SPARE: begin
          d.spare = wdata_i;
        end
        accdet_pkg::ADDR_CLKCTL: begin
          d.scan_clk = wdata_i[accdet_pkg::SCAN_BIT];
          d.clk_rsvd = wdata_i[6:0];
        end
        accdet_pkg::ADDR_POWER: begin
          d.power_on = wdata_i[accdet_pkg::PWR_BIT];
          d.sleep = wdata_i[accdet_pkg::SLEEP_BIT];
        end
        accdet_pkg::ADDR_TEST_SEL: begin
          d.test_sel = wdata_i;
        end
        accdet_pkg::ADDR_TEST_VAL: begin
          d.test_val = wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Sequencer updates come after the register writes so that a result
    // landing in the same cycle as a software write is not lost.
    unique case (q.phase)
      accdet_pkg::PH_IDLE: begin
        if (start) begin
          av.clear = 1'b1;
          d.rep_left = 3'((4'h1 << q.pulse_count) - 4'h1);
          d.tick_cnt = 8'h00;
          d.samp_cnt = 4'h0;
          d.pulse = 1'b1;
          d.run_level = q.pulse_level;
          d.run_count = q.pulse_count;
          d.phase = accdet_pkg::PH_PULSE;
        end
      end
      accdet_pkg::PH_PULSE: begin
        if (pulse_end) begin
          av.valid = 1'b1;
          d.pulse = 1'b0;
          d.samp_cnt = q.samp_cnt + 4'h1;
          d.rep_left = q.rep_left - 3'h1;
          d.phase = (q.rep_left == 3'h0) ? accdet_pkg::PH_FINISH
                                         : accdet_pkg::PH_GAP;
        end else if (tick) begin
          d.tick_cnt = q.tick_cnt + 8'h01;
        end
      end
      accdet_pkg::PH_GAP: begin
        if (tick) begin
          d.tick_cnt = 8'h00;
          d.pulse = 1'b1;
          d.phase = accdet_pkg::PH_PULSE;
        end
      end
      accdet_pkg::PH_FINISH: begin
        if (q.report_mode) begin
          d.state_code = result;
        end
        d.phase = accdet_pkg::PH_IDLE;
      end
    endcase

    // Pulling the accessory out ends any run and clears the reported code.
    if (q.ins_prev && !inserted) begin
      d.pulse = 1'b0;
      d.phase = accdet_pkg::PH_IDLE;
      if (q.report_mode) begin
        d.state_code = accdet_pkg::CODE_NONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.report_mode <= accdet_pkg::STATE_RST[accdet_pkg::REPORT_BIT];
      q.state_code <= accdet_pkg::STATE_RST[6:0];
      q.filter_sel <= accdet_pkg::PULSE_RST[accdet_pkg::FILTER_BIT];
      q.pulse_count <= accdet_pkg::PULSE_RST[accdet_pkg::COUNT_LSB +: 2];
      q.pulse_width <= accdet_pkg::PULSE_RST[accdet_pkg::WIDTH_LSB +: 2];
      q.pulse_level <= accdet_pkg::PULSE_RST[accdet_pkg::LEVEL_LSB +: 2];
      q.spare <= accdet_pkg::SPARE_RST;
      q.scan_clk <= accdet_pkg::CLKCTL_RST[accdet_pkg::SCAN_BIT];
      q.clk_rsvd <= accdet_pkg::CLKCTL_RST[6:0];
      q.power_on <= accdet_pkg::POWER_RST[accdet_pkg::PWR_BIT];
      q.sleep <= accdet_pkg::POWER_RST[accdet_pkg::SLEEP_BIT];
      q.test_sel <= accdet_pkg::TEST_RST;
      q.test_val <= accdet_pkg::TEST_RST;
      q.phase <= accdet_pkg::PH_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign pulse_o = q.pulse;
  assign pulse_level_o = q.run_level;
  assign busy_o = (q.phase != accdet_pkg::PH_IDLE);
  assign load_state_o = q.state_code;
  assign inserted_o = inserted;
  assign power_on_o = q.power_on;
  // Sleep has no meaning while the device is powered down.
  assign sleep_mode_o = q.sleep && q.power_on;
  assign scan_clk_en_o = q.scan_clk && inserted && q.power_on && !q.sleep;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_run_start;
    (q.phase == accdet_pkg::PH_IDLE) ##1 (q.phase == accdet_pkg::PH_PULSE);
  endsequence

  sequence s_removal;
    q.ins_prev && !inserted && q.report_mode;
  endsequence

  a_run_cause: assert property (
    s_run_start |-> $past(q.power_on) && !$past(q.power_prev))
    else $error("Detection started without a power-on rise.");

  a_code_remove: assert property (
    s_removal |=> q.state_code == accdet_pkg::CODE_NONE && q.phase == accdet_pkg::PH_IDLE)
    else $error("Removal did not report an empty jack.");

  a_result_legal: assert property (
    q.phase == accdet_pkg::PH_FINISH && q.report_mode && inserted
    |=> accdet_pkg::code_known(q.state_code) || q.state_code == accdet_pkg::CODE_UNSUP)
    else $error("Reported code is outside the table.");

  a_sample_count: assert property (
    q.phase == accdet_pkg::PH_FINISH |-> q.samp_cnt == (4'h1 << q.run_count))
    else $error("Wrong number of pulse tests in a run.");

  a_pulse_len: assert property (
    $fell(q.pulse) && q.phase != accdet_pkg::PH_IDLE
    |-> q.pulse_len <= 15'(accdet_pkg::width_us(q.pulse_width)) * 15'(accdet_pkg::US_CYCLES)
     && q.pulse_len > 15'(width_last) * 15'(accdet_pkg::US_CYCLES))
    else $error("Test pulse width is wrong.");

  a_level_track: assert property (
    s_run_start |-> pulse_level_o == $past(q.pulse_level) && pulse_o)
    else $error("Pulse level not taken at run start.");

  a_scan_gate: assert property (
    ($rose(q.sleep) || $fell(q.power_on) || $fell(inserted)) |-> !scan_clk_en_o)
    else $error("Scan clock left on outside an active headset.");

  a_force_hold: assert property (
    !q.report_mode && !(wr_i && addr_i == accdet_pkg::ADDR_STATE) |=> $stable(q.state_code))
    else $error("Forced code changed without a write.");

endmodule : accessory_detect_config

//--- accessory_model.sv
// Behavioural headset in the jack: switch level and a classifier code per test pulse.
module accessory_model (
  // Clock and pulse from the block
  input wire logic clk_i,
  input wire logic pulse_i,
  // Bench control
  input wire logic plugged_i,
  // Jack side
  output logic jack_open_o,
  output logic [6:0] probe_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] codes [$];
  logic [6:0] noise = 7'h55;
  logic pulse_q = 1'b0;
  initial probe_code_o = 7'h2A;
  task automatic load(input logic [6:0] c);
    codes.push_back(c);
  endtask : load
  task automatic flush();
    codes.delete();
  endtask : flush
  // The switch opens only while a plug sits in the jack.
  assign jack_open_o = plugged_i;
  // A new load appears only after the pulse that measured the previous one has ended.
  // With no plug the terminals float, so the code wanders every cycle.
  always @(posedge clk_i) begin
    pulse_q <= pulse_i;
    noise <= noise + 7'h1D;
    if (pulse_q && !pulse_i && codes.size() > 0) begin
      void'(codes.pop_front());
    end
    if (!plugged_i) begin
      probe_code_o <= noise;
    end else if (codes.size() > 0) begin
      probe_code_o <= codes[0];
    end else begin
      probe_code_o <= 7'h1F;
    end
  end
endmodule : accessory_model

//--- avg_if.sv
// Link between the pulse sequencer and the result averager.
interface avg_if;
  logic clear;
  logic valid;
  logic [6:0] sample;
  logic [1:0] shift;
  logic [6:0] mean;
  modport ctrl (output clear, output valid, output sample, output shift, input mean);
  modport calc (input clear, input valid, input sample, input shift, output mean);
endinterface : avg_if

//--- jack_filter.sv
// Asymmetric debounce of the jack switch level.
module jack_filter #(
  parameter int INS_FAST = 3000,
  parameter int REM_FAST = 12000,
  parameter int INS_SLOW = 20000,
  parameter int REM_SLOW = 80000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Microsecond enable, synchronised level and time select
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic slow_i,
  // Filtered level, high while an accessory sits in the jack
  output logic level_o
);

  typedef struct packed {
    logic level;
    logic [16:0] cnt;
  } filt_t;

  filt_t q;
  filt_t d;
  logic [16:0] limit;

  always_comb begin
    if (q.level) begin
      limit = slow_i ? 17'(REM_SLOW) : 17'(REM_FAST);
    end else begin
      limit = slow_i ? 17'(INS_SLOW) : 17'(INS_FAST);
    end
  end

  always_comb begin
    d = q;
    if (raw_i == q.level) begin
      d.cnt = 17'h00000;
    end else if (tick_i) begin
      if (q.cnt >= limit - 17'h00001) begin
        d.level = raw_i;
        d.cnt = 17'h00000;
      end else begin
        d.cnt = q.cnt + 17'h00001;
      end
    end
  end

  assign level_o = q.level;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_filter_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(q.level) |-> $past(tick_i) && $past(q.cnt) >= $past(limit) - 17'h00001)
    else $error("Jack level changed before its filter time.");

endmodule : jack_filter

//--- pulse_avg.sv
// Accumulates pulse test results and divides by the repeat count.
module pulse_avg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sequencer link
  avg_if.calc av
);

  typedef struct packed {
    logic [9:0] sum;
  } avg_t;

  avg_t q;
  avg_t d;

  always_comb begin
    d = q;
    if (av.clear) begin
      d.sum = 10'h000;
    end else if (av.valid) begin
      d.sum = q.sum + {3'h0, av.sample};
    end
  end

  // Eight samples of 127 fit in ten bits, so the sum never wraps.
  assign av.mean = 7'(q.sum >> av.shift);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Samples arrive a whole pulse apart, so each step is checked on its own edge.
  sequence s_cleared;
    av.clear;
  endsequence

  sequence s_take;
    av.valid && !av.clear;
  endsequence

  a_avg_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_cleared |=> q.sum == 10'h000)
    else $error("Sum not cleared at run start.");

  a_avg_accum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_take |=> q.sum == $past(q.sum) + {3'h0, $past(av.sample)})
    else $error("Sample not added to the sum.");

endmodule : pulse_avg

//--- tb_top.sv
// Self-checking bench for the accessory detection register bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INS_F = 4;
  localparam int REM_F = 8;
  localparam int INS_S = 6;
  localparam int REM_S = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic plugged = 1'b0;
  logic jack_open_i;
  logic [6:0] probe_code_i;
  logic [7:0] rdata_o;
  logic pulse_o;
  logic busy_o;
  logic inserted_o;
  logic power_on_o;
  logic sleep_mode_o;
  logic scan_clk_en_o;
  logic [1:0] pulse_level_o;
  logic [6:0] load_state_o;
  logic [7:0] v;
  int bad_count = 0;
  int compares = 0;
  logic [6:0] tbl [15] = '{7'h01, 7'h02, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F,
                           7'h10, 7'h11, 7'h12, 7'h1A, 7'h1B, 7'h1C, 7'h1F};

  accessory_detect_config #(
    .DEB_INS_FAST_US(INS_F),
    .DEB_REM_FAST_US(REM_F),
    .DEB_INS_SLOW_US(INS_S),
    .DEB_REM_SLOW_US(REM_S)
  ) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .jack_open_i(jack_open_i), .probe_code_i(probe_code_i),
    .pulse_o(pulse_o), .pulse_level_o(pulse_level_o), .busy_o(busy_o),
    .load_state_o(load_state_o), .inserted_o(inserted_o), .power_on_o(power_on_o),
    .sleep_mode_o(sleep_mode_o), .scan_clk_en_o(scan_clk_en_o)
  );

  accessory_model u_acc (
    .clk_i(clk_i), .pulse_i(pulse_o), .plugged_i(plugged),
    .jack_open_o(jack_open_i), .probe_code_o(probe_code_i)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata_o, exp);
  endtask : rdchk

  // The average is taken over the codes as numbers; an off-table mean reads as unsupported.
  function automatic logic [6:0] to_code(input logic [9:0] sum, input int sh);
    logic [6:0] m;
    m = 7'(sum >> sh);
    to_code = 7'h1F;
    foreach (tbl[i]) if (tbl[i] === m) to_code = m;
  endfunction : to_code

  function automatic int pw_us(input logic [1:0] s);
    case (s)
      2'h0: pw_us = 50;
      2'h1: pw_us = 25;
      2'h2: pw_us = 100;
      default: pw_us = 200;
    endcase
  endfunction : pw_us

  task automatic meas(input logic lvl, input int us);
    int n;
    n = 0;
    @(posedge clk_i);
    plugged <= lvl;
    while (inserted_o !== lvl && n < 20000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("jack_time", 8'(n >= (us - 1) * 125 && n <= (us + 1) * 125 + 8), 8'h01);
  endtask : meas

  task automatic run_det(input logic [1:0] cnt, input logic [1:0] ws, input logic [1:0] ls);
    int n, w, k, len, pulses, bad_w;
    logic [9:0] sum;
    logic [6:0] c;
    n = 1 << cnt;
    w = pw_us(ws);
    sum = '0;
    pulses = 0;
    bad_w = 0;
    for (k = 0; k < n; k++) begin
      c = tbl[$urandom_range(14)];
      sum += 10'(c);
      u_acc.load(c);
    end
    wr(8'h1A, {2'b00, cnt, ws, ls});
    wr(8'h1D, 8'h00);
    wr(8'h1D, 8'h80);
    k = 0;
    while (busy_o !== 1'b1 && k < 8) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check("busy", {7'h00, busy_o}, 8'h01);
    check("level", {6'h00, pulse_level_o}, {6'h00, ls});
    len = (pulse_o === 1'b1) ? 1 : 0;
    k = 0;
    while (busy_o === 1'b1 && k < n * (w + 2) * 125 + 500) begin
      @(posedge clk_i);
      #1;
      k++;
      if (pulse_o === 1'b1) begin
        len++;
      end else if (len > 0) begin
        pulses++;
        if (len < (w - 1) * 125 + 1 || len > w * 125) bad_w++;
        len = 0;
      end
    end
    check("pulses", 8'(pulses), 8'(n));
    check("widths", 8'(bad_w), 8'h00);
    rdchk(8'h19, {1'b1, to_code(sum, int'(cnt))});
    check("load", {1'b0, load_state_o}, {1'b0, to_code(sum, int'(cnt))});
  endtask : run_det

  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // The tests need about 110000 cycles; the limit of 150000 leaves good margin.
  initial begin
    #1200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h6BD3));
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(8'h19, 8'h80);
    rdchk(8'h1A, 8'h15);
    rdchk(8'h1B, 8'h00);
    rdchk(8'h1C, 8'h01);
    rdchk(8'h1D, 8'h00);
    rdchk(8'h20, 8'h00);
    wr(8'h1C, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(8'h1A, v);
      rdchk(8'h1A, v & 8'hBF);
      wr(8'h1B, ~v);
      rdchk(8'h1B, ~v);
    end
    wr(8'h19, 8'h00);
    check("load", {1'b0, load_state_o}, 8'h00);
    foreach (tbl[i]) begin
      wr(8'h19, {1'b0, tbl[i]});
      check("load", {1'b0, load_state_o}, {1'b0, tbl[i]});
    end
    wr(8'h19, 8'h80);
    wr(8'h1A, 8'h80);
    meas(1'b1, INS_S);
    meas(1'b0, REM_S);
    wr(8'h1A, 8'h00);
    meas(1'b1, INS_F);
    run_det(2'h0, 2'h3, 2'h0);
    run_det(2'h1, 2'h2, 2'h1);
    run_det(2'h2, 2'h0, 2'h2);
    run_det(2'h3, 2'h1, 2'h3);
    wr(8'h66, 8'hF1);
    wr(8'h6F, 8'h01);
    wr(8'h66, 8'h00);
    wr(8'h1C, 8'h80);
    check("scan_on", {7'h00, scan_clk_en_o}, 8'h01);
    rdchk(8'h6F, 8'h01);
    wr(8'h1D, 8'hC0);
    check("scan_sleep", {6'h00, sleep_mode_o, scan_clk_en_o}, 8'h02);
    wr(8'h66, 8'hF1);
    wr(8'h6F, 8'h00);
    wr(8'h66, 8'h00);
    wr(8'h1C, 8'h00);
    rdchk(8'h6F, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h19, 8'h80);
    repeat (4) @(posedge clk_i);
    #1;
    check("no_rerun", {7'h00, busy_o}, 8'h00);
    for (int i = 0; i < 8; i++) u_acc.load(tbl[$urandom_range(14)]);
    wr(8'h1A, 8'h35);
    wr(8'h1D, 8'h00);
    wr(8'h1D, 8'h80);
    repeat (50) @(posedge clk_i);
    meas(1'b0, REM_F);
    repeat (2) @(posedge clk_i);
    #1;
    check("abort", {busy_o, pulse_o, 6'h00}, 8'h00);
    check("removed", {1'b0, load_state_o}, 8'h00);
    u_acc.flush();
    wr(8'h1D, 8'h00);
    wr(8'h1D, 8'h80);
    repeat (4) @(posedge clk_i);
    #1;
    check("no_plug", {6'h00, power_on_o, busy_o}, 8'h02);
    tally_and_finish();
  end
endmodule : tb_top
